// *** shared/dgo_defs.svh ***
// constants of the global operation-control block: offsets, fields, reset and timing
`ifndef DGO_DEFS_SVH
`define DGO_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DGO_OPER_OFFSET     12'h000
`define DGO_DECODE_MSB      11
`define DGO_OPER_RESET      32'h00000000
`define DGO_OPER_WMASK      32'h3301003c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DGO_PACE_HI_BIT     29
`define DGO_PACE_LO_BIT     28
`define DGO_PRIO_HI_BIT     25
`define DGO_PRIO_LO_BIT     24
`define DGO_AE_BIT          18
`define DGO_NONMASKABLE_EVENT_FLAG_BIT        17
`define DGO_DME_BIT         16
`define DGO_RC0_BIT         5
`define DGO_RC3_BIT         2

// ----------------------------------------------------------------
// bus encodings
// ----------------------------------------------------------------
`define DGO_HSIZE_WORD      3'h2
`define DGO_HRESP_OKAY      1'h0

// ----------------------------------------------------------------
// intermittent pacing, in external bus clocks, and the channel treated as last served after reset, so rotation starts from the one after it
// ----------------------------------------------------------------
`define DGO_PACE16_CLKS     7'h10
`define DGO_PACE64_CLKS     7'h40
`define DGO_CHAN_LAST_RESET 2'h3

`endif

// *** shared/dgo_pkg.sv ***
// types of the global operation-control block
`default_nettype none

package dgo_pkg;

    // ----------------------------------------------------------------
    // transfer sequencer
    // ----------------------------------------------------------------
    typedef enum logic {
        DGO_ST_IDLE,
        DGO_ST_ACTIVE
    } dgo_xfer_state_t;

    // ----------------------------------------------------------------
    // field encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DGO_PRIO_FIXED1 = 2'h0,
        DGO_PRIO_FIXED2 = 2'h1,
        DGO_PRIO_RC_SEL = 2'h2,
        DGO_PRIO_RR_ALL = 2'h3
    } dgo_prio_mode_t;

    typedef enum logic [1:0] {
        DGO_PACE_NORMAL = 2'h0,
        DGO_PACE_RSVD   = 2'h1,
        DGO_PACE_INT16  = 2'h2,
        DGO_PACE_INT64  = 2'h3
    } dgo_pace_mode_t;

endpackage

`default_nettype wire

// *** verilog/dgo_arbiter.sv ***
// channel priority picker: fixed orders and round-robin among selected channels
`timescale 1ns/1ps
`default_nettype none

module dgo_arbiter
    import dgo_pkg::*;
(
    // configuration
    input  wire logic [1:0] prio_mode,
    input  wire logic [3:0] round_robin_select_bits,
    input  wire logic [1:0] last_chan,
    // requests and pick
    input  wire logic [3:0] req,
    output logic            pick_valid,
    output logic [1:0]      pick_chan
);

    logic [1:0] order [4];
    logic [1:0] rot   [4];
    logic [3:0] rr_set;
    logic [2:0] n_rot;
    logic [2:0] used;
    logic [1:0] c;

    // ----------------------------------------------------------------
    // build the priority order, highest first
    // ----------------------------------------------------------------
    always_comb begin
        rr_set = 4'h0;
        n_rot  = 3'h0;
        used   = 3'h0;
        c      = 2'h0;
        for (int i = 0; i < 4; i++) begin
            order[i] = 2'(i);
            rot[i]   = 2'(i);
        end
        unique case (dgo_prio_mode_t'(prio_mode))
            DGO_PRIO_FIXED1: rr_set = 4'h0;
            DGO_PRIO_FIXED2: begin
                order[0] = 2'h0;
                order[1] = 2'h2;
                order[2] = 2'h3;
                order[3] = 2'h1;
            end
            DGO_PRIO_RC_SEL: rr_set = round_robin_select_bits;
            DGO_PRIO_RR_ALL: rr_set = 4'hf;
        endcase
        // rotation only applies once the finished channel is itself selected
        if (rr_set[last_chan]) begin
            for (int i = 1; i <= 4; i++) begin
                c = last_chan + 2'(i);
                if (rr_set[c]) begin
                    rot[n_rot[1:0]] = c;
                    n_rot = n_rot + 3'h1;
                end
            end
            for (int s = 0; s < 4; s++) begin
                if (rr_set[s]) begin
                    order[s] = rot[used[1:0]];
                    used = used + 3'h1;
                end
            end
        end
        pick_valid = 1'b0;
        pick_chan  = 2'h0;
        for (int s = 3; s >= 0; s--) begin
            if (req[order[s]]) begin
                pick_valid = 1'b1;
                pick_chan  = order[s];
            end
        end
    end

endmodule

`default_nettype wire

// *** verilog/dgo_top.sv ***
// global operation-control register, arbitration and pacing of a four-channel dma
`timescale 1ns/1ps
`default_nettype none
`include "dgo_defs.svh"

module dgo_top
    import dgo_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // power state
    input  wire logic        chip_standby,
    input  wire logic        module_standby,
    // pins
    input  wire logic        nmi_pin,
    input  wire logic        ext_bus_clk_pin,
    // per-channel status and the all-channel cycle-steal mode from the channel registers
    input  wire logic [3:0]  channel_transfer_enable,
    input  wire logic [3:0]  transfer_end_flag,
    input  wire logic        all_cycle_steal,
    // transfer engine
    input  wire logic [3:0]  chan_req,
    input  wire logic        unit_done,
    input  wire logic        addr_error,
    output logic [3:0]       chan_grant,
    output logic             xfer_halted
);

    // ----------------------------------------------------------------
    // register fields
    // ----------------------------------------------------------------
    logic [1:0]      pace_q;
    logic [1:0]      prio_q;
    logic [3:0]      rc_q;
    logic            ae_q;
    logic            nonmaskable_event_flag_q;
    logic            dme_q;
    logic            ae_armed_q;
    logic            nonmaskable_event_flag_armed_q;

    // ----------------------------------------------------------------
    // bus state
    // ----------------------------------------------------------------
    logic            wr_pend_q;
    logic            rd_pend_q;
    logic            hit_q;
    logic            hready_q;
    logic [31:0]     hrdata_q;

    // ----------------------------------------------------------------
    // synchronisers and pacing
    // ----------------------------------------------------------------
    logic            nmi_s1_q;
    logic            nmi_s2_q;
    logic            nmi_s3_q;
    logic            ebc_s1_q;
    logic            ebc_s2_q;
    logic            ebc_s3_q;
    logic [6:0]      pace_cnt_q;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    dgo_xfer_state_t state_q;
    logic [1:0]      cur_q;
    logic [1:0]      last_q;
    logic [3:0]      grant_q;
    logic            halted_q;

    logic            frozen;
    logic            addr_ok;
    logic            wr_do;
    logic            cfg_change;
    logic            nmi_event;
    logic            ebc_rise;
    logic            pace_ok;
    logic [3:0]      eligible;
    logic            start_ok;
    logic            pick_valid;
    logic [1:0]      pick_chan;
    logic            ae_set;
    logic            nonmaskable_event_flag_set;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] oper_value(
        input logic [1:0] pace,
        input logic [1:0] prio,
        input logic [3:0] rc,
        input logic       ae,
        input logic       nonmaskable_event_flag,
        input logic       master_transfer_enable
    );
        logic [31:0] v;
        v = 32'h00000000;
        v[`DGO_PACE_HI_BIT:`DGO_PACE_LO_BIT] = pace;
        v[`DGO_PRIO_HI_BIT:`DGO_PRIO_LO_BIT] = prio;
        v[`DGO_AE_BIT]   = ae;
        v[`DGO_NONMASKABLE_EVENT_FLAG_BIT] = nonmaskable_event_flag;
        v[`DGO_DME_BIT]  = master_transfer_enable;
        for (int n = 0; n < 4; n++) begin
            v[`DGO_RC0_BIT - n] = rc[n];
        end
        return v;
    endfunction

    function automatic logic [3:0] onehot(input logic [1:0] ch);
        return 4'h1 << ch;
    endfunction

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    assign frozen  = chip_standby | module_standby;
    assign addr_ok = (haddr[`DGO_DECODE_MSB:0] == `DGO_OPER_OFFSET);
    assign wr_do   = wr_pend_q & hit_q & ~frozen;

    // reads get one wait state so a write just before is always visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            hit_q     <= 1'b0;
            hready_q  <= 1'b1;
            hrdata_q  <= 32'h00000000;
        end else begin
            wr_pend_q <= 1'b0;
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                hready_q  <= 1'b1;
                hrdata_q  <= hit_q ? oper_value(pace_q, prio_q, rc_q, ae_q, nonmaskable_event_flag_q, dme_q)
                                   : 32'h00000000;
            end else if (hsel && htrans[1] && hready) begin
                hit_q <= addr_ok;
                if (hwrite) begin
                    wr_pend_q <= (hsize == `DGO_HSIZE_WORD);
                end else begin
                    rd_pend_q <= 1'b1;
                    hready_q  <= 1'b0;
                end
            end
        end
    end

    assign hreadyout = hready_q;
    assign hrdata    = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= `DGO_HRESP_OKAY;
        end else begin
            hresp <= `DGO_HRESP_OKAY;
        end
    end

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    assign cfg_change = wr_do &&
        ((hwdata[`DGO_PRIO_HI_BIT:`DGO_PRIO_LO_BIT] != prio_q) ||
         (hwdata[`DGO_RC0_BIT] != rc_q[0]) || (hwdata[`DGO_RC0_BIT-1] != rc_q[1]) ||
         (hwdata[`DGO_RC0_BIT-2] != rc_q[2]) || (hwdata[`DGO_RC3_BIT] != rc_q[3]));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pace_q <= 2'(`DGO_OPER_RESET >> `DGO_PACE_LO_BIT);
            prio_q <= 2'h0;
            rc_q   <= 4'h0;
            dme_q  <= 1'b0;
        end else if (wr_do) begin
            pace_q <= hwdata[`DGO_PACE_HI_BIT:`DGO_PACE_LO_BIT];
            prio_q <= hwdata[`DGO_PRIO_HI_BIT:`DGO_PRIO_LO_BIT];
            dme_q  <= hwdata[`DGO_DME_BIT];
            for (int n = 0; n < 4; n++) begin
                rc_q[n] <= hwdata[`DGO_RC0_BIT - n];
            end
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    assign ae_set   = addr_error & (state_q == DGO_ST_ACTIVE) & ~frozen;
    assign nonmaskable_event_flag_set = nmi_event & ~frozen;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ae_q <= 1'b0;
        end else if (ae_set) begin
            ae_q <= 1'b1;
        end else if (wr_do && ae_armed_q && !hwdata[`DGO_AE_BIT]) begin
            ae_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nonmaskable_event_flag_q <= 1'b0;
        end else if (nonmaskable_event_flag_set) begin
            nonmaskable_event_flag_q <= 1'b1;
        end else if (wr_do && nonmaskable_event_flag_armed_q && !hwdata[`DGO_NONMASKABLE_EVENT_FLAG_BIT]) begin
            nonmaskable_event_flag_q <= 1'b0;
        end
    end

    // a read returning one arms the clear; any word-size write that hits the register outside standby disarms it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ae_armed_q   <= 1'b0;
            nonmaskable_event_flag_armed_q <= 1'b0;
        end else if (rd_pend_q && hit_q) begin
            ae_armed_q   <= ae_q;
            nonmaskable_event_flag_armed_q <= nonmaskable_event_flag_q;
        end else if (wr_do) begin
            ae_armed_q   <= 1'b0;
            nonmaskable_event_flag_armed_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
            nmi_s3_q <= 1'b0;
            ebc_s1_q <= 1'b0;
            ebc_s2_q <= 1'b0;
            ebc_s3_q <= 1'b0;
        end else begin
            nmi_s1_q <= nmi_pin;
            nmi_s2_q <= nmi_s1_q;
            nmi_s3_q <= nmi_s2_q;
            ebc_s1_q <= ext_bus_clk_pin;
            ebc_s2_q <= ebc_s1_q;
            ebc_s3_q <= ebc_s2_q;
        end
    end

    assign nmi_event = nmi_s2_q & ~nmi_s3_q;
    assign ebc_rise  = ebc_s2_q & ~ebc_s3_q;

    // ----------------------------------------------------------------
    // intermittent pacing
    // ----------------------------------------------------------------
    // counts external bus clocks since the last start, saturating at the long interval
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pace_cnt_q <= `DGO_PACE64_CLKS;
        end else if (!frozen) begin
            if (state_q == DGO_ST_IDLE && start_ok && pick_valid) begin
                pace_cnt_q <= 7'h00;
            end else if (ebc_rise && pace_cnt_q != `DGO_PACE64_CLKS) begin
                pace_cnt_q <= pace_cnt_q + 7'h01;
            end
        end
    end

    always_comb begin
        pace_ok = 1'b1;
        if (all_cycle_steal) begin
            unique case (dgo_pace_mode_t'(pace_q))
                DGO_PACE_NORMAL: pace_ok = 1'b1;
                DGO_PACE_RSVD:   pace_ok = 1'b1;
                DGO_PACE_INT16:  pace_ok = (pace_cnt_q >= `DGO_PACE16_CLKS);
                DGO_PACE_INT64:  pace_ok = (pace_cnt_q >= `DGO_PACE64_CLKS);
            endcase
        end
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    assign eligible = chan_req & channel_transfer_enable & ~transfer_end_flag;
    assign start_ok = dme_q & ~ae_q & ~nonmaskable_event_flag_q & pace_ok & ~frozen;

    dgo_arbiter u_arbiter (
        .prio_mode               (prio_q),
        .round_robin_select_bits (rc_q),
        .last_chan               (last_q),
        .req                     (eligible),
        .pick_valid              (pick_valid),
        .pick_chan               (pick_chan)
    );

    // ----------------------------------------------------------------
    // transfer sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= DGO_ST_IDLE;
            cur_q   <= 2'h0;
            grant_q <= 4'h0;
        end else if (!frozen) begin
            unique case (state_q)
                DGO_ST_IDLE: begin
                    if (start_ok && pick_valid) begin
                        state_q <= DGO_ST_ACTIVE;
                        cur_q   <= pick_chan;
                        grant_q <= onehot(pick_chan);
                    end
                end
                DGO_ST_ACTIVE: begin
                    if (!dme_q || !channel_transfer_enable[cur_q] || ae_q || ae_set) begin
                        state_q <= DGO_ST_IDLE;
                        grant_q <= 4'h0;
                    end else if (unit_done) begin
                        state_q <= DGO_ST_IDLE;
                        grant_q <= 4'h0;
                    end
                end
            endcase
        end
    end

    // finished channel drives rotation; a priority reconfiguration restarts it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_q <= `DGO_CHAN_LAST_RESET;
        end else if (cfg_change) begin
            last_q <= `DGO_CHAN_LAST_RESET;
        end else if (state_q == DGO_ST_ACTIVE && unit_done && !frozen) begin
            last_q <= cur_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halted_q <= 1'b0;
        end else begin
            halted_q <= ae_q | nonmaskable_event_flag_q | ~dme_q;
        end
    end

    assign chan_grant  = grant_q;
    assign xfer_halted = halted_q;

endmodule

`default_nettype wire

// *** bench/dgo_top_chk.sv ***
// port-level assertion checker for the operation-control block
`timescale 1ns/1ps
`default_nettype none

module dgo_top_chk (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // power state
    input wire logic       chip_standby,
    input wire logic       module_standby,
    // transfer engine
    input wire logic [3:0] chan_req,
    input wire logic [3:0] channel_transfer_enable,
    input wire logic [3:0] transfer_end_flag,
    input wire logic       unit_done,
    input wire logic       addr_error,
    input wire logic [3:0] chan_grant,
    input wire logic       xfer_halted
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_taken(w);
        hsel && htrans[1] && hready && hwrite == w;
    endsequence
    sequence s_read_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_BUS_OKAY:
        assert property (hresp == 1'b0) else $error("bus response not okay");
    AST_WRITE_NO_WAIT:
        assert property (s_taken(1'b1) |=> hreadyout) else $error("write stalled");
    AST_READ_ONE_WAIT:
        assert property (s_taken(1'b0) |=> s_read_answer) else $error("read wait wrong");
    AST_GRANT_ONE_HOT:
        assert property ($onehot0(chan_grant)) else $error("grant not one-hot");
    AST_GRANT_ELIGIBLE:
        assert property (chan_grant != 4'h0 && $past(chan_grant) == 4'h0 |->
            ($past(chan_req) & $past(channel_transfer_enable) & ~$past(transfer_end_flag)
             & chan_grant) != 4'h0) else $error("grant to ineligible channel");
    AST_HALT_BLOCKS_START:
        assert property (xfer_halted && $past(chan_grant) == 4'h0 |-> chan_grant == 4'h0)
            else $error("start while halted");
    AST_ERROR_ABORTS:
        assert property (chan_grant != 4'h0 && addr_error && !chip_standby && !module_standby
            |=> chan_grant == 4'h0) else $error("address error did not abort");
    AST_ERROR_HALTS:
        assert property (chan_grant != 4'h0 && addr_error && !chip_standby && !module_standby
            |-> ##2 xfer_halted) else $error("address error did not halt");
    AST_DONE_ENDS_UNIT:
        assert property (chan_grant != 4'h0 && unit_done && !chip_standby && !module_standby
            |=> chan_grant == 4'h0) else $error("grant outlived unit");
endmodule

bind dgo_top dgo_top_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .chip_standby, .module_standby, .chan_req,
    .channel_transfer_enable, .transfer_end_flag, .unit_done, .addr_error, .chan_grant,
    .xfer_halted);
`default_nettype wire

// *** bench/dgo_top_bench.sv ***
// self-checking bench for the operation-control block
`timescale 1ns/1ps
`default_nettype none
`include "dgo_defs.svh"

module dgo_top_bench
    import dgo_pkg::*;
;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, unit_done = 0;
    logic        chip_standby = 0, module_standby = 0, nmi_pin = 0, ext_bus_clk_pin = 0;
    logic        all_cycle_steal = 1, addr_error = 0;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = `DGO_HSIZE_WORD;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [3:0]  channel_transfer_enable = 4'hf, transfer_end_flag = 0, chan_req = 0;
    wire logic   hreadyout, hresp, xfer_halted;
    wire logic [31:0] hrdata;
    wire logic [3:0]  chan_grant;
    int          err_count = 0, comparisons = 0;

    always #25 hclk = ~hclk;
    // four bus clocks per external clock, slow enough for the two-stage sampler
    always #100 ext_bus_clk_pin = ~ext_bus_clk_pin;

    dgo_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .chip_standby, .module_standby,
        .nmi_pin, .ext_bus_clk_pin, .channel_transfer_enable, .transfer_end_flag,
        .all_cycle_steal, .chan_req, .unit_done, .addr_error, .chan_grant, .xfer_halted);

    // ----
    // shared tasks
    // ----
    function automatic logic [31:0] cfg(input logic [1:0] p, input logic [1:0] m,
                                        input logic [3:0] rc);
        return {2'h0, p, 2'h0, m, 8'h01, 10'h0, rc, 2'h0};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, {20'h0, `DGO_OPER_OFFSET}, d, q);
    endtask

    task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, q, exp);
    endtask

    // waits for a grant, checks it, then ends the unit
    task automatic grab(input logic [3:0] req, input logic [3:0] exp, input int lim,
                        output int n);
        chan_req <= req;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (chan_grant === 4'h0 && n < lim);
        chk("grant", {28'h0, chan_grant}, {28'h0, exp});
        @(posedge hclk);
        unit_done <= 1'b1;
        chan_req <= 4'h0;
        @(posedge hclk);
        unit_done <= 1'b0;
    endtask

    task automatic pace_case(input dgo_pace_mode_t p, input logic s, input int lo, input int hi);
        int n;
        all_cycle_steal <= s;
        wr(cfg(p, DGO_PRIO_FIXED1, 4'h0));
        grab(4'h1, 4'h1, 300, n);
        grab(4'h1, 4'h1, 300, n);
        chk("pacing gap", {31'h0, n > lo && n <= hi}, 32'h1);
    endtask

    task automatic flag_clear(input string what, input logic [31:0] f);
        int n;
        grab(4'h1, 4'h0, 6, n);
        chk("halted", {31'h0, xfer_halted}, 32'h1);
        wr(32'h00010000 | f);
        wr(32'h00010000);
        rd(what, 32'h0, 32'h00010000 | f);
        wr(32'h00010000);
        rd(what, 32'h0, 32'h00010000);
    endtask

    task automatic close_out;
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_regs;
        int n;
        rd("reset value", 32'h0, `DGO_OPER_RESET);
        grab(4'hf, 4'h0, 6, n);
        wr(32'hffffffff);
        rd("writable bits", 32'h0, `DGO_OPER_WMASK);
        rd("unmapped", 32'h100, 32'h0);
        for (int i = 0; i < 2; i++) begin
            chip_standby <= (i == 0);
            module_standby <= (i == 1);
            wr(32'h0);
            rd("standby hold", 32'h0, `DGO_OPER_WMASK);
        end
        chip_standby <= 1'b0;
        module_standby <= 1'b0;
    endtask

    task automatic t_prio;
        int n;
        wr(cfg(DGO_PACE_NORMAL, DGO_PRIO_FIXED1, 4'h0));
        grab(4'hf, 4'h1, 8, n);
        grab(4'he, 4'h2, 8, n);
        transfer_end_flag <= 4'h2;
        grab(4'he, 4'h4, 8, n);
        transfer_end_flag <= 4'h0;
        channel_transfer_enable <= 4'hb;
        grab(4'hc, 4'h8, 8, n);
        channel_transfer_enable <= 4'hf;
        wr(cfg(DGO_PACE_NORMAL, DGO_PRIO_FIXED2, 4'h0));
        grab(4'he, 4'h4, 8, n);
        grab(4'ha, 4'h8, 8, n);
        wr(cfg(DGO_PACE_NORMAL, DGO_PRIO_RC_SEL, 4'h0));
        grab(4'h3, 4'h1, 8, n);
        grab(4'h3, 4'h1, 8, n);
        wr(cfg(DGO_PACE_NORMAL, DGO_PRIO_RC_SEL, 4'hf));
        grab(4'h3, 4'h1, 8, n);
        grab(4'h3, 4'h2, 8, n);
        wr(cfg(DGO_PACE_NORMAL, DGO_PRIO_RR_ALL, 4'h0));
        grab(4'h3, 4'h1, 8, n);
        grab(4'h3, 4'h2, 8, n);
        grab(4'h3, 4'h1, 8, n);
    endtask

    task automatic t_flags;
        wr(cfg(DGO_PACE_NORMAL, DGO_PRIO_FIXED1, 4'h0));
        chan_req <= 4'h1;
        do @(negedge hclk); while (chan_grant === 4'h0);
        @(posedge hclk);
        addr_error <= 1'b1;
        @(posedge hclk);
        addr_error <= 1'b0;
        chan_req <= 4'h0;
        @(negedge hclk);
        chk("abort", {28'h0, chan_grant}, 32'h0);
        @(posedge hclk);
        flag_clear("address error", 32'h00040000);
        chan_req <= 4'h1;
        do @(negedge hclk); while (chan_grant === 4'h0);
        @(posedge hclk);
        nmi_pin <= 1'b1;
        repeat (6) @(negedge hclk);
        chk("unit finishes", {28'h0, chan_grant}, 32'h1);
        @(posedge hclk);
        unit_done <= 1'b1;
        chan_req <= 4'h0;
        nmi_pin <= 1'b0;
        @(posedge hclk);
        unit_done <= 1'b0;
        flag_clear("event flag", 32'h00020000);
        wr(32'h0);
        nmi_pin <= 1'b1;
        repeat (6) @(posedge hclk);
        rd("event while idle", 32'h0, 32'h00020000);
    endtask

    initial begin
        #1000000;
        err_count++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_prio();
        pace_case(DGO_PACE_INT16, 1'b1, 56, 68);
        pace_case(DGO_PACE_INT64, 1'b1, 248, 260);
        pace_case(DGO_PACE_INT16, 1'b0, 0, 3);
        pace_case(DGO_PACE_NORMAL, 1'b1, 0, 3);
        t_flags();
        close_out();
    end
endmodule
`default_nettype wire
